/* core/ocfe_output_enable.sv */
`timescale 1ns/1ps
`default_nettype none
module ocfe_output_enable (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        ref_clk_zero_src_in,
  input  wire logic        frame_pulse_zero_src_in,
  input  wire logic        ref_clk_one_src_in,
  input  wire logic        frame_pulse_one_src_in,
  input  wire logic        ref_clk_two_src_in,
  input  wire logic        frame_pulse_two_src_in,
  input  wire logic        ref_clk_three_src_in,
  input  wire logic        frame_pulse_three_src_in,
  input  wire logic        t1_e1_clk_src_in,
  input  wire logic        extra_clk_src_in,
  input  wire logic        offset_pulse_a_src_in,
  input  wire logic        offset_pulse_b_src_in,
  output logic             ref_clk_out_zero_out,
  output logic             ref_clk_out_zero_oe_out,
  output logic             frame_pulse_out_zero_out,
  output logic             frame_pulse_out_zero_oe_out,
  output logic             ref_clk_out_one_out,
  output logic             ref_clk_out_one_oe_out,
  output logic             frame_pulse_out_one_out,
  output logic             frame_pulse_out_one_oe_out,
  output logic             ref_clk_out_two_out,
  output logic             ref_clk_out_two_oe_out,
  output logic             frame_pulse_out_two_out,
  output logic             frame_pulse_out_two_oe_out,
  output logic             ref_clk_out_three_out,
  output logic             ref_clk_out_three_oe_out,
  output logic             frame_pulse_out_three_out,
  output logic             frame_pulse_out_three_oe_out,
  output logic             t1_e1_clk_out_out,
  output logic             t1_e1_clk_out_oe_out,
  output logic             extra_clk_out_out,
  output logic             extra_clk_out_oe_out,
  output logic             offset_frame_pulse_a_out,
  output logic             offset_frame_pulse_a_oe_out,
  output logic             offset_frame_pulse_b_out,
  output logic             offset_frame_pulse_b_oe_out
);

  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] sel_r;
  logic [15:0] sel_nxt;
  logic [15:0] mode_r;
  logic [15:0] mode_nxt;
  logic        wr_pend_r;
  logic [29:0] wr_idx_r;
  logic        addr_take;
  logic [15:0] rd_nxt;
  logic [11:0] src;
  logic [11:0] oe_r;
  logic [11:0] oe_nxt;
  logic [11:0] pin_r;
  logic        t1e1_allowed;
  logic        hready_r;
  logic        hresp_r;
  logic [31:0] hrdata_r;

  // address phase is taken only when the bus is ready
  assign addr_take = hsel_in && hready_in && (htrans_in == ocfe_pkg::HTRANS_NSQ || htrans_in == 2'h3);

  // sources arrive from the clock generator on core_clk_in, no sync needed
  assign src = {offset_pulse_b_src_in, offset_pulse_a_src_in,
                extra_clk_src_in, t1_e1_clk_src_in,
                frame_pulse_three_src_in, ref_clk_three_src_in,
                frame_pulse_two_src_in, ref_clk_two_src_in,
                frame_pulse_one_src_in, ref_clk_one_src_in,
                frame_pulse_zero_src_in, ref_clk_zero_src_in};

  // write takes effect at the end of the data phase
  always_comb begin
    ctrl_nxt = ctrl_r;
    sel_nxt  = sel_r;
    mode_nxt = mode_r;
    if (wr_pend_r) begin
      unique case (wr_idx_r)
        ocfe_pkg::CTRL_IDX: ctrl_nxt = hwdata_in[15:0] & ocfe_pkg::CTRL_MASK;
        ocfe_pkg::SEL_IDX:  sel_nxt  = hwdata_in[15:0];
        ocfe_pkg::MODE_IDX: mode_nxt = hwdata_in[15:0] & ocfe_pkg::MODE_MASK;
        default: ;
      endcase
    end
  end

  // reads see the value a write in the same cycle is storing
  always_comb begin
    rd_nxt = 16'h0000;
    unique case (haddr_in[31:2])
      ocfe_pkg::CTRL_IDX: rd_nxt = ctrl_nxt;
      ocfe_pkg::SEL_IDX:  rd_nxt = sel_nxt;
      ocfe_pkg::MODE_IDX: rd_nxt = mode_nxt;
      ocfe_pkg::STAT_IDX: rd_nxt = {4'h0, oe_r};
      default:            rd_nxt = 16'h0000;
    endcase
  end

  assign t1e1_allowed = mode_r[ocfe_pkg::MODE_MSTR] || mode_r[ocfe_pkg::MODE_SPLL];

  // one enable bit steers both pins of a pair
  always_comb begin
    oe_nxt                      = 12'h000;
    oe_nxt[1:0]                 = {2{ctrl_r[0]}};
    oe_nxt[3:2]                 = {2{ctrl_r[1]}};
    oe_nxt[5:4]                 = {2{ctrl_r[2]}};
    oe_nxt[7:6]                 = {2{ctrl_r[3]}};
    oe_nxt[ocfe_pkg::PIN_T1E1]  = ctrl_r[ocfe_pkg::EN_T1E1] && t1e1_allowed;
    oe_nxt[ocfe_pkg::PIN_EXTRA] = ctrl_r[ocfe_pkg::EN_EXTRA];
    oe_nxt[ocfe_pkg::PIN_OFFA]  = ctrl_r[ocfe_pkg::EN_OFFA];
    oe_nxt[ocfe_pkg::PIN_OFFB]  = ctrl_r[ocfe_pkg::EN_OFFB];
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= ocfe_pkg::CTRL_RST;
      sel_r  <= ocfe_pkg::SEL_RST;
      mode_r <= ocfe_pkg::MODE_RST;
    end else if (ce_in) begin
      ctrl_r <= ctrl_nxt;
      sel_r  <= sel_nxt;
      mode_r <= mode_nxt;
    end
  end

  // hsize is not decoded: only whole-word transfers are expected
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 30'h0000_0000;
    end else if (ce_in) begin
      wr_pend_r <= addr_take && hwrite_in;
      wr_idx_r  <= haddr_in[31:2];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ce_in) begin
      if (addr_take && !hwrite_in) begin
        hrdata_r <= {16'h0000, rd_nxt};
      end else begin
        hrdata_r <= 32'h0000_0000;
      end
    end
  end

  // zero wait states, always okay; unmapped reads give zero
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
    end else if (ce_in) begin
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
    end
  end

  // a tristated pin also drives low so no stale level leaks out
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oe_r  <= ocfe_pkg::PIN_RST;
      pin_r <= ocfe_pkg::PIN_RST;
    end else if (ce_in) begin
      oe_r  <= oe_nxt;
      pin_r <= src & oe_nxt;
    end
  end

  assign hrdata_out                   = hrdata_r;
  assign hreadyout_out                = hready_r;
  assign hresp_out                    = hresp_r;
  assign ref_clk_out_zero_out         = pin_r[0];
  assign ref_clk_out_zero_oe_out      = oe_r[0];
  assign frame_pulse_out_zero_out     = pin_r[1];
  assign frame_pulse_out_zero_oe_out  = oe_r[1];
  assign ref_clk_out_one_out          = pin_r[2];
  assign ref_clk_out_one_oe_out       = oe_r[2];
  assign frame_pulse_out_one_out      = pin_r[3];
  assign frame_pulse_out_one_oe_out   = oe_r[3];
  assign ref_clk_out_two_out          = pin_r[4];
  assign ref_clk_out_two_oe_out       = oe_r[4];
  assign frame_pulse_out_two_out      = pin_r[5];
  assign frame_pulse_out_two_oe_out   = oe_r[5];
  assign ref_clk_out_three_out        = pin_r[6];
  assign ref_clk_out_three_oe_out     = oe_r[6];
  assign frame_pulse_out_three_out    = pin_r[7];
  assign frame_pulse_out_three_oe_out = oe_r[7];
  assign t1_e1_clk_out_out            = pin_r[8];
  assign t1_e1_clk_out_oe_out         = oe_r[8];
  assign extra_clk_out_out            = pin_r[9];
  assign extra_clk_out_oe_out         = oe_r[9];
  assign offset_frame_pulse_a_out     = pin_r[10];
  assign offset_frame_pulse_a_oe_out  = oe_r[10];
  assign offset_frame_pulse_b_out     = pin_r[11];
  assign offset_frame_pulse_b_oe_out  = oe_r[11];

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_ctrl_wr;
    addr_take && hwrite_in && ce_in && haddr_in[31:2] == ocfe_pkg::CTRL_IDX
    ##1 ce_in;
  endsequence

  sequence s_pins_follow;
    ce_in;
  endsequence

  a_ctrl_write: assert property (
    s_ctrl_wr |=> ctrl_r == ($past(hwdata_in[15:0]) & ocfe_pkg::CTRL_MASK))
    else $error("control write not stored");

  a_upper_zero: assert property (
    ctrl_r[15:9] == 7'h00)
    else $error("control upper bits not zero");

  a_pair_three: assert property (
    s_ctrl_wr ##1 s_pins_follow |=> oe_r[7:6] == {2{$past(hwdata_in[3], 2)}})
    else $error("pair three enable not applied after write");

  a_pair_three_off: assert property (
    ce_in && !ctrl_r[3] |=> !oe_r[6] && !oe_r[7] && !pin_r[6] && !pin_r[7])
    else $error("pair three driven while disabled");

  a_pair_two: assert property (
    ce_in |=> oe_r[5:4] == {2{$past(ctrl_r[2])}})
    else $error("pair two enable mismatch");

  a_pair_one: assert property (
    ce_in && ctrl_r[1] |=> oe_r[2] && oe_r[3] && pin_r[2] == $past(src[2]))
    else $error("pair one not driven");

  a_pair_one_off: assert property (
    ce_in && !ctrl_r[1] |=> oe_r[3:2] == 2'b00)
    else $error("pair one not tristated");

  a_pair_zero: assert property (
    ce_in |=> oe_r[0] == oe_r[1] && oe_r[0] == $past(ctrl_r[0]))
    else $error("pair zero enable mismatch");

  a_t1e1_gate: assert property (
    ce_in && !mode_r[ocfe_pkg::MODE_MSTR] && !mode_r[ocfe_pkg::MODE_SPLL]
    |=> !oe_r[ocfe_pkg::PIN_T1E1] && !pin_r[ocfe_pkg::PIN_T1E1])
    else $error("t1/e1 clock out of allowed mode");

  a_t1e1_on: assert property (
    ce_in && ctrl_r[ocfe_pkg::EN_T1E1] && mode_r[ocfe_pkg::MODE_SPLL]
    |=> oe_r[ocfe_pkg::PIN_T1E1])
    else $error("t1/e1 clock not enabled");

  a_extra_group: assert property (
    ce_in |=> oe_r[11:9] == $past(ctrl_r[7:5]))
    else $error("offset or extra enable mismatch");

  a_freeze_pins: assert property (
    !ce_in |=> $stable(oe_r) && $stable(pin_r) && $stable(ctrl_r))
    else $error("state moved while clock enable low");

  a_stat_read: assert property (
    addr_take && !hwrite_in && ce_in && haddr_in[31:2] == ocfe_pkg::STAT_IDX
    |=> hrdata_out == {20'h0_0000, $past(oe_r)})
    else $error("status read wrong");

  a_bus_ready: assert property (
    hreadyout_out && !hresp_out)
    else $error("bus answer not ready okay");

endmodule : ocfe_output_enable
`default_nettype wire

/* inc/ocfe_pkg.sv */
// How it works
// - bit 3 set drives clock three and frame pulse three, clear tristates both
// - bit 2 set drives clock two and frame pulse two, clear tristates both
// - bit 1 set drives clock one and frame pulse one, clear tristates both
// - bit 0 set drives clock zero and frame pulse zero, clear tristates both
// - t1/e1 clock runs only in master mode or with slave pll enabled
`default_nettype none
package ocfe_pkg;
  // printed offsets are word indexes; byte address is four times the index
  localparam logic [29:0] CTRL_IDX   = 30'h0000_0003;
  localparam logic [29:0] SEL_IDX    = 30'h0000_0004;
  localparam logic [29:0] MODE_IDX   = 30'h0000_0005;
  localparam logic [29:0] STAT_IDX   = 30'h0000_0006;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] SEL_RST    = 16'h0000;
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [15:0] CTRL_MASK  = 16'h01FF;
  localparam logic [15:0] MODE_MASK  = 16'h0003;
  localparam int unsigned EN_T1E1    = 4;
  localparam int unsigned EN_EXTRA   = 5;
  localparam int unsigned EN_OFFA    = 6;
  localparam int unsigned EN_OFFB    = 7;
  localparam int unsigned MODE_MSTR  = 0;
  localparam int unsigned MODE_SPLL  = 1;
  localparam int unsigned PIN_N      = 12;
  localparam int unsigned PIN_T1E1   = 8;
  localparam int unsigned PIN_EXTRA  = 9;
  localparam int unsigned PIN_OFFA   = 10;
  localparam int unsigned PIN_OFFB   = 11;
  localparam logic [1:0]  HTRANS_NSQ = 2'h2;
  localparam logic [11:0] PIN_RST    = 12'h000;
endpackage : ocfe_pkg
`default_nettype wire

/* verification/ocfe_pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ocfe_pin_partner (
  input  wire logic        core_clk_in,
  input  wire logic [11:0] pin_in,
  input  wire logic [11:0] oe_in,
  output logic      [11:0] line_out
);
  logic [11:0] last_r = 12'h000;
  // a released line toggles every cycle, so a stale level never passes for a driven one
  always @(posedge core_clk_in) begin
    last_r <= line_out;
  end
  always_comb begin
    line_out = (pin_in & oe_in) | (~last_r & ~oe_in);
  end
endmodule : ocfe_pin_partner
`default_nettype wire

/* verification/output_clock_frame_enable_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module output_clock_frame_enable_tb_top;
  logic        core_clk_in = 1'b0;
  logic        rst_n_in    = 1'b0;
  logic        ce          = 1'b1;
  logic        hsel        = 1'b0;
  logic        hwrite      = 1'b0;
  logic [1:0]  htrans      = 2'h0;
  logic [2:0]  hsize       = 3'h2;
  logic [31:0] haddr       = 32'h0000_0000;
  logic [31:0] hwdata      = 32'h0000_0000;
  logic [11:0] src_v       = 12'hfff;
  logic [31:0] rd;
  logic [15:0] c;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  wire  [11:0] pin_v;
  wire  [11:0] oe_v;
  wire  [11:0] line_v;
  int          n_errors    = 0;
  int          checks_done = 0;
  always #4 core_clk_in = ~core_clk_in;

  ocfe_output_enable ocfe_output_enable_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .ref_clk_zero_src_in(src_v[0]), .frame_pulse_zero_src_in(src_v[1]), .ref_clk_one_src_in(src_v[2]),
    .frame_pulse_one_src_in(src_v[3]), .ref_clk_two_src_in(src_v[4]), .frame_pulse_two_src_in(src_v[5]),
    .ref_clk_three_src_in(src_v[6]), .frame_pulse_three_src_in(src_v[7]), .t1_e1_clk_src_in(src_v[8]),
    .extra_clk_src_in(src_v[9]), .offset_pulse_a_src_in(src_v[10]), .offset_pulse_b_src_in(src_v[11]),
    .ref_clk_out_zero_out(pin_v[0]), .ref_clk_out_zero_oe_out(oe_v[0]),
    .frame_pulse_out_zero_out(pin_v[1]), .frame_pulse_out_zero_oe_out(oe_v[1]),
    .ref_clk_out_one_out(pin_v[2]), .ref_clk_out_one_oe_out(oe_v[2]),
    .frame_pulse_out_one_out(pin_v[3]), .frame_pulse_out_one_oe_out(oe_v[3]),
    .ref_clk_out_two_out(pin_v[4]), .ref_clk_out_two_oe_out(oe_v[4]),
    .frame_pulse_out_two_out(pin_v[5]), .frame_pulse_out_two_oe_out(oe_v[5]),
    .ref_clk_out_three_out(pin_v[6]), .ref_clk_out_three_oe_out(oe_v[6]),
    .frame_pulse_out_three_out(pin_v[7]), .frame_pulse_out_three_oe_out(oe_v[7]),
    .t1_e1_clk_out_out(pin_v[8]), .t1_e1_clk_out_oe_out(oe_v[8]),
    .extra_clk_out_out(pin_v[9]), .extra_clk_out_oe_out(oe_v[9]),
    .offset_frame_pulse_a_out(pin_v[10]), .offset_frame_pulse_a_oe_out(oe_v[10]),
    .offset_frame_pulse_b_out(pin_v[11]), .offset_frame_pulse_b_oe_out(oe_v[11])
  );

  ocfe_pin_partner ocfe_pin_partner_inst (
    .core_clk_in(core_clk_in), .pin_in(pin_v), .oe_in(oe_v), .line_out(line_v)
  );

  task automatic xfer(input logic w, input logic [29:0] idx, input logic [31:0] wd);
    @(posedge core_clk_in);
    hsel   <= 1'b1;
    htrans <= ocfe_pkg::HTRANS_NSQ;
    hwrite <= w;
    haddr  <= {idx, 2'b00};
    do @(posedge core_clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk_in); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask : xfer

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [11:0] exp_oe(input logic [15:0] v, input logic [1:0] m);
    exp_oe = {v[7], v[6], v[5], v[4] & (m[0] | m[1]), {2{v[3]}}, {2{v[2]}}, {2{v[1]}}, {2{v[0]}}};
  endfunction : exp_oe

  task automatic check_state(input logic [15:0] v, input logic [1:0] m);
    logic [11:0] e;
    e = exp_oe(v, m);
    xfer(1'b0, ocfe_pkg::CTRL_IDX, 32'h0000_0000);
    chk("ctrl", {16'h0000, v & 16'h01ff}, rd);
    xfer(1'b0, ocfe_pkg::MODE_IDX, 32'h0000_0000);
    chk("mode", {30'h0000_0000, m}, rd);
    xfer(1'b0, ocfe_pkg::STAT_IDX, 32'h0000_0000);
    chk("status", {20'h0_0000, e}, rd);
    #1;
    chk("oe", {20'h0_0000, e}, {20'h0_0000, oe_v});
    chk("pins", {20'h0_0000, e & src_v}, {20'h0_0000, pin_v});
    chk("lines", {20'h0_0000, e & src_v}, {20'h0_0000, line_v & e});
  endtask : check_state

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 3; i < 8; i++) begin
      xfer(1'b0, 30'(i), 32'h0000_0000);
      chk("reset or unmapped read", 32'h0000_0000, rd);
    end
    check_state(16'h0000, 2'h0);
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 9; i++) begin
        c = 16'h0001 << i;
        xfer(1'b1, ocfe_pkg::MODE_IDX, 32'(m));
        xfer(1'b1, ocfe_pkg::CTRL_IDX, {16'h0000, c});
        check_state(c, 2'(m));
      end
    end
    $display("test single enables done");
    // host keeps the reserved upper control bits at zero
    xfer(1'b1, ocfe_pkg::CTRL_IDX, 32'h0000_01ff);
    check_state(16'h01ff, 2'h3);
    @(posedge core_clk_in);
    src_v <= 12'h000;
    check_state(16'h01ff, 2'h3);
    $display("test all enables done");
    // sources change while the clock enable is low: pins must hold
    @(posedge core_clk_in);
    ce    <= 1'b0;
    src_v <= 12'hfff;
    repeat (4) @(posedge core_clk_in);
    #1;
    chk("frozen pins", 32'h0000_0000, {20'h0_0000, pin_v});
    chk("frozen oe", {20'h0_0000, exp_oe(16'h01ff, 2'h3)}, {20'h0_0000, oe_v});
    @(posedge core_clk_in);
    ce <= 1'b1;
    check_state(16'h01ff, 2'h3);
    $display("test clock enable done");
    xfer(1'b1, ocfe_pkg::SEL_IDX, 32'h0000_a5a5);
    xfer(1'b0, ocfe_pkg::SEL_IDX, 32'h0000_0000);
    chk("select", 32'h0000_a5a5, rd);
    xfer(1'b1, 30'h0000_0007, 32'h0000_1234);
    xfer(1'b0, 30'h0000_0007, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    $display("test select and unmapped done");
    report_and_stop();
  end
endmodule : output_clock_frame_enable_tb_top
`default_nettype wire
